// file: ilo_addr_gen.v
// Data-memory address generator for byte- and bit-oriented instructions.
// Assumes the decode stage presents one opcode per cycle with a valid strobe
// and that software sets up mode, bank and pointers over APB.
// Function
// - Indexed mode only when extended set enabled.
// - a=0 and f<=5Fh selects indexed mode.
// - Indexed address is pointer two plus f.
// - a=0, f>=60h maps to F60h..FFFh.
// - Forced mode reaches 000h..05Fh only for low access without extended set.
// - a=1 uses bank select with f.
// - Offsets 00h-5Fh form window at pointer.
// - Without extended set, low access hits bank 0.
// - Indirect operands stay standard indirect addressing.
// - Pointers zero and one unchanged by mode.
// - Inherent and literal instructions bypass generation.
// - Memory size and register map unchanged.
// - Bank select works as in legacy mode.
// - f bits 7:0, a bit 8, d bit 9.
// - Banked address is bank concatenated with f.
// - Pointers hold 12 bits; upper nibble ignored.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "ilo_regs.vh"
module ilo_addr_gen #(
  parameter AW = 12
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire op_valid,
  input wire [15:0] opcode,
  input wire [1:0] op_class,
  input wire [1:0] indirect_sel,
  output reg addr_valid,
  output reg [AW-1:0] data_addr,
  output reg dest_file,
  output reg [2:0] addr_mode
);
  // ****************************************
  // Registers
  // ****************************************
  reg extended_set_enable_q;
  reg [3:0] bank_select_value_q;
  reg [AW-1:0] pointer_pair_zero_q;
  reg [AW-1:0] pointer_pair_one_q;
  reg [AW-1:0] frame_pointer_two_q;
  reg [15:0] count_q;

  // ****************************************
  // Bus handshake
  // ****************************************
  wire setup_phase;
  wire wr_en;
  assign setup_phase = psel & ~penable;
  assign wr_en = psel & penable & pwrite & pready;

  // The slave answers in the first access cycle, so pready rises with penable.
  // A fixed zero-wait answer keeps the master simple; no register needs more time.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  // ****************************************
  // Register write decode
  // ****************************************
  wire wr_ctrl;
  wire wr_bank;
  wire wr_ptr0;
  wire wr_ptr1;
  wire wr_ptr2;
  assign wr_ctrl = wr_en & (paddr == `ILO_REG_CTRL);
  assign wr_bank = wr_en & (paddr == `ILO_REG_BANK);
  assign wr_ptr0 = wr_en & (paddr == `ILO_REG_PTR0);
  assign wr_ptr1 = wr_en & (paddr == `ILO_REG_PTR1);
  assign wr_ptr2 = wr_en & (paddr == `ILO_REG_PTR2);

  // ****************************************
  // Mode and bank registers
  // ****************************************
  // The mode bit stands in for a configuration fuse, so software may change it at run time.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extended_set_enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      extended_set_enable_q <= pwdata[`ILO_CTRL_EXT_BIT];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_select_value_q <= 4'h0;
    end else if (wr_bank) begin
      bank_select_value_q <= pwdata[`ILO_BANK_MSB:0];
    end
  end

  // ****************************************
  // Pointer registers
  // ****************************************
  // Only the low AW bits are kept; the upper bits of each word read back as zero.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pointer_pair_zero_q <= {AW{1'b0}};
    end else if (wr_ptr0) begin
      pointer_pair_zero_q <= pwdata[AW-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pointer_pair_one_q <= {AW{1'b0}};
    end else if (wr_ptr1) begin
      pointer_pair_one_q <= pwdata[AW-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_pointer_two_q <= {AW{1'b0}};
    end else if (wr_ptr2) begin
      frame_pointer_two_q <= pwdata[AW-1:0];
    end
  end

  // ****************************************
  // Read side and unmapped answer
  // ****************************************
  // The status word shows the last result; its valid bit is only a one-cycle pulse.
  wire [31:0] status_word;
  assign status_word = {25'h0, addr_mode, 3'h0, addr_valid};
  reg [31:0] rdata_d;
  reg mapped_d;
  always @* begin
    rdata_d = 32'h0;
    mapped_d = 1'b1;
    case (paddr)
      `ILO_REG_CTRL: rdata_d = {31'h0, extended_set_enable_q};
      `ILO_REG_BANK: rdata_d = {28'h0, bank_select_value_q};
      `ILO_REG_PTR0: rdata_d = {{(32-AW){1'b0}}, pointer_pair_zero_q};
      `ILO_REG_PTR1: rdata_d = {{(32-AW){1'b0}}, pointer_pair_one_q};
      `ILO_REG_PTR2: rdata_d = {{(32-AW){1'b0}}, frame_pointer_two_q};
      `ILO_REG_STAT: rdata_d = status_word;
      `ILO_REG_COUNT: rdata_d = {16'h0, count_q};
      default: mapped_d = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle, so it stands through the access cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup_phase) begin
      prdata <= rdata_d;
    end
  end

  // An unmapped address answers with an error but is otherwise ignored.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= ~mapped_d;
    end else if (pready) begin
      pslverr <= 1'b0;
    end
  end

  // ****************************************
  // Opcode fields
  // ****************************************
  wire [7:0] f_field;
  wire a_bit;
  wire d_bit;
  wire cls_file;
  wire cls_indirect;
  wire access_high;
  assign f_field = opcode[`ILO_F_MSB:0];
  assign a_bit = opcode[`ILO_A_BIT];
  assign d_bit = opcode[`ILO_D_BIT];
  assign cls_file = (op_class == `ILO_CLS_FILE);
  assign cls_indirect = (op_class == `ILO_CLS_INDIRECT);
  assign access_high = (f_field >= `ILO_ACCESS_SPLIT);

  // ****************************************
  // Candidate addresses
  // ****************************************
  wire [AW-1:0] banked_addr;
  wire [AW-1:0] forced_addr;
  wire [AW-1:0] legacy_low_addr;
  wire [AW-1:0] indexed_addr;
  // The bank register works the same in both modes.
  assign banked_addr = {bank_select_value_q, f_field};
  // Forced access with f at 60h or above lands in bank 15; low forced access without extended set uses bank 0.
  assign forced_addr = {`ILO_BANK15, f_field};
  assign legacy_low_addr = {`ILO_BANK0, f_field};
  // Truncation lets the window wrap past the top of memory.
  assign indexed_addr = frame_pointer_two_q + {{(AW-8){1'b0}}, f_field};

  // ****************************************
  // Indirect pointer select
  // ****************************************
  reg [AW-1:0] ind_ptr;
  // Indirect operands ignore the extended mode entirely.
  always @* begin
    ind_ptr = frame_pointer_two_q;
    case (indirect_sel)
      `ILO_SEL_PTR0: ind_ptr = pointer_pair_zero_q;
      `ILO_SEL_PTR1: ind_ptr = pointer_pair_one_q;
      default: ind_ptr = frame_pointer_two_q;
    endcase
  end

  // ****************************************
  // Address select
  // ****************************************
  // The access bit decides first, then the split of the access range, then the mode bit.
  reg [AW-1:0] addr_d;
  reg [2:0] mode_d;
  always @* begin
    addr_d = {AW{1'b0}};
    mode_d = `ILO_MODE_NONE;
    case (op_class)
      `ILO_CLS_FILE: begin
        if (a_bit) begin
          addr_d = banked_addr;
          mode_d = `ILO_MODE_BANKED;
        end else if (access_high) begin
          addr_d = forced_addr;
          mode_d = `ILO_MODE_FORCED;
        end else if (extended_set_enable_q) begin
          addr_d = indexed_addr;
          mode_d = `ILO_MODE_INDEXED;
        end else begin
          addr_d = legacy_low_addr;
          mode_d = `ILO_MODE_FORCED;
        end
      end
      `ILO_CLS_INDIRECT: begin
        addr_d = ind_ptr;
        mode_d = `ILO_MODE_INDIRECT;
      end
      default: begin
        mode_d = `ILO_MODE_NONE;
      end
    endcase
  end

  // ****************************************
  // Result registers
  // ****************************************
  // The unused class code is no operand class, so it must not raise the strobe.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_valid <= 1'b0;
    end else begin
      addr_valid <= op_valid & (cls_file | cls_indirect);
    end
  end

  // Address, destination and mode hold until the next opcode.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_addr <= {AW{1'b0}};
    end else if (op_valid) begin
      data_addr <= addr_d;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dest_file <= 1'b0;
    end else if (op_valid) begin
      dest_file <= d_bit & cls_file;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_mode <= `ILO_MODE_NONE;
    end else if (op_valid) begin
      addr_mode <= mode_d;
    end
  end

  // ****************************************
  // Indexed-mode counter
  // ****************************************
  // It wraps silently; software reads it only as a usage figure.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 16'h0;
    end else if (op_valid & (mode_d == `ILO_MODE_INDEXED)) begin
      count_q <= count_q + 16'h1;
    end
  end
endmodule // ilo_addr_gen

// file: ilo_chk_properties.sv
// Checker of the address generator's port relations.
// Bound into ilo_addr_gen; it sees only that module's ports.
`timescale 1ns/1ps
module ilo_chk #(parameter AW = 12) (
  input wire pclk, presetn, psel, penable, pready, op_valid, addr_valid, dest_file,
  input wire [15:0] opcode,
  input wire [1:0] op_class,
  input wire [AW-1:0] data_addr,
  input wire [2:0] addr_mode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // File operand with the access bit clear.
  wire fv = op_valid && op_class == 2'h1 && !opcode[8];
  property p_bank; op_valid && op_class == 2'h1 && opcode[8] |=>
    addr_mode == 3'h1 && data_addr[7:0] == $past(opcode[7:0]); endproperty
  a_bank: assert property (p_bank) else $error("banked wrong");
  property p_frc; fv && opcode[7:0] >= 8'h60 |=>
    addr_mode == 3'h2 && data_addr == {4'hf, $past(opcode[7:0])}; endproperty
  a_frc: assert property (p_frc) else $error("forced wrong");
  property p_low; fv && opcode[7:0] < 8'h60 |=>
    addr_mode == 3'h3 || (addr_mode == 3'h2 && data_addr == {4'h0, $past(opcode[7:0])});
  endproperty
  a_low: assert property (p_low) else $error("low access wrong");
  property p_idx; addr_mode == 3'h3 && $past(op_valid) |->
    $past(fv) && $past(opcode[7:0]) < 8'h60; endproperty
  a_idx: assert property (p_idx) else $error("indexed cause wrong");
  property p_none; op_valid && op_class[0] == op_class[1] |=>
    !addr_valid && addr_mode == 3'h0; endproperty
  a_none: assert property (p_none) else $error("bypass wrong");
  property p_ind; op_valid && op_class == 2'h2 |=> addr_valid && addr_mode == 3'h4;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect wrong");
  property p_dst; op_valid |=>
    dest_file == ($past(op_class) == 2'h1 && $past(opcode[9])); endproperty
  a_dst: assert property (p_dst) else $error("dest wrong");
  // Zero wait states: ready in the first access cycle only.
  property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready wrong");
endmodule // ilo_chk
bind ilo_addr_gen ilo_chk #(.AW(AW)) u_chk(.pclk, .presetn, .psel, .penable, .pready,
  .op_valid, .addr_valid, .dest_file, .opcode, .op_class, .data_addr, .addr_mode);

// file: ilo_dec.sv
// Decode-stage model: one opcode strobe per call.
// Called right after a rising edge; opcode and pointer select change once the strobe ends.
`timescale 1ns/1ps
module ilo_dec (
  input wire pclk,
  output logic op_valid = 0,
  output logic [15:0] opcode = 0,
  output logic [1:0] op_class = 0,
  output logic [1:0] indirect_sel = 0
);
  task automatic issue(input logic [1:0] c, s, input logic [15:0] o);
    op_valid <= 1;
    op_class <= c;
    indirect_sel <= s;
    opcode <= o;
    @(posedge pclk);
    op_valid <= 0;
    opcode <= ~o;
    indirect_sel <= ~s;
  endtask
endmodule // ilo_dec

// file: ilo_regs.vh
// Constants for the data-memory address generator: opcode fields, address ranges
// and the APB register map. Assumes a 12-bit data memory and 16-bit opcodes.
`ifndef ILO_REGS_VH
`define ILO_REGS_VH
// ****************************************
// Opcode fields
// ****************************************
`define ILO_F_MSB 7
`define ILO_A_BIT 8
`define ILO_D_BIT 9
// ****************************************
// Address ranges
// ****************************************
`define ILO_ACCESS_SPLIT 8'h60
`define ILO_BANK15 4'hf
`define ILO_BANK0 4'h0
// ****************************************
// Operand classes from decode
// ****************************************
`define ILO_CLS_NONE 2'h0
`define ILO_CLS_FILE 2'h1
`define ILO_CLS_INDIRECT 2'h2
// ****************************************
// Indirect pointer select codes
// ****************************************
`define ILO_SEL_PTR0 2'h0
`define ILO_SEL_PTR1 2'h1
// ****************************************
// Register fields
// ****************************************
`define ILO_CTRL_EXT_BIT 0
`define ILO_BANK_MSB 3
// ****************************************
// Address modes reported
// ****************************************
`define ILO_MODE_NONE 3'h0
`define ILO_MODE_BANKED 3'h1
`define ILO_MODE_FORCED 3'h2
`define ILO_MODE_INDEXED 3'h3
`define ILO_MODE_INDIRECT 3'h4
// ****************************************
// APB register map
// ****************************************
`define ILO_REG_CTRL 12'h000
`define ILO_REG_BANK 12'h004
`define ILO_REG_PTR0 12'h008
`define ILO_REG_PTR1 12'h00c
`define ILO_REG_PTR2 12'h010
`define ILO_REG_STAT 12'h014
`define ILO_REG_COUNT 12'h018
`endif

// file: tb.sv
// Bench: APB set-up, then opcodes through the decode model.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, addr_valid, dest_file, op_valid;
  logic [15:0] opcode;
  logic [1:0] op_class, indirect_sel;
  logic [11:0] data_addr;
  logic [2:0] addr_mode;
  int err_count = 0, total_checks = 0, cyc = 0;
  always #5 pclk = ~pclk;
  ilo_addr_gen dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .op_valid, .opcode, .op_class, .indirect_sel, .addr_valid,
    .data_addr, .dest_file, .addr_mode);
  ilo_dec dec(.pclk, .op_valid, .opcode, .op_class, .indirect_sel);
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic op(input logic [1:0] c, s, input logic [15:0] o, input logic [11:0] a,
    input logic [2:0] m);
    dec.issue(c, s, o);
    #1;
    chk("valid", c == 1 || c == 2, addr_valid);
    chk("mode", m, addr_mode);
    if (c != 0) chk("addr", a, data_addr);
    chk("dest", c == 1 && o[9], dest_file);
    @(posedge pclk);
  endtask
  task automatic t_regs;
    apb(0, 12'h000, 0);
    chk("ctrl", 0, rd);
    apb(1, 12'h008, 32'h0000_0abc);
    apb(1, 12'h00c, 32'h0000_0123);
    apb(1, 12'h010, 32'hffff_ffd0);
    apb(0, 12'h010, 0);
    chk("ptr2", 32'h0000_0fd0, rd);
    apb(0, 12'h01c, 0);
    chk("slverr", 1, er);
    chk("unmapped data", 0, rd);
    $display("test regs done");
  endtask
  task automatic t_legacy;
    apb(1, 12'h004, 32'h0000_0005);
    op(1, 0, 16'h0020, 12'h020, 3'h2);
    op(1, 0, 16'h0333, 12'h533, 3'h1);
    op(2, 1, 16'h0000, 12'h123, 3'h4);
    $display("test legacy done");
  endtask
  task automatic t_ext;
    apb(1, 12'h000, 32'h0000_0001);
    op(1, 0, 16'h005f, 12'h02f, 3'h3);
    op(1, 0, 16'h0200, 12'hfd0, 3'h3);
    op(1, 0, 16'h0060, 12'hf60, 3'h2);
    op(1, 0, 16'h01ff, 12'h5ff, 3'h1);
    op(2, 0, 16'h0000, 12'habc, 3'h4);
    op(2, 2, 16'h0005, 12'hfd0, 3'h4);
    apb(0, 12'h014, 0);
    chk("status", 32'h0000_0040, rd);
    apb(0, 12'h018, 0);
    chk("count", 32'h0000_0002, rd);
    op(0, 0, 16'h0010, 12'h000, 3'h0);
    op(3, 0, 16'h0010, 12'h000, 3'h0);
    $display("test ext done");
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs;
    t_legacy;
    t_ext;
    give_verdict;
  end
  // A hang must end in the same verdict path.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      give_verdict;
    end
  end
endmodule // tb
